// *** hw/eds_regs.svh ***
// Register offsets, field positions, reset values and cycle counts for extended data addressing
`ifndef EDS_REGS_SVH
`define EDS_REGS_SVH

`define EDS_OFF_RD_PAGE 8'h00
`define EDS_OFF_WR_PAGE 8'h04
`define EDS_OFF_STATUS 8'h08
`define EDS_OFF_MASK 8'h0C
`define EDS_OFF_LAST_ADDR 8'h10
`define EDS_OFF_RUN 8'h14

`define EDS_RD_PAGE_RESET 10'h001
`define EDS_WR_PAGE_RESET 9'h001
`define EDS_EVT_RESET 3'h0

`define EDS_EVT_TRAP 0
`define EDS_EVT_PSV 1
`define EDS_EVT_REACH 2
`define EDS_EVT_W 3

`define EDS_PSV_BIT 9
`define EDS_WINDOW_BIT 15
`define EDS_LAST_EXT_BIT 24

`define EDS_WRITE_CYCLES 2'h1
`define EDS_EXT_READ_CYCLES 2'h2
`define EDS_REP_FIRST_CYCLES 2'h3
`define EDS_REP_LATER_CYCLES 2'h1
`define EDS_REP_SLOW_COUNT 2'h2

`define EDS_EXT_WIDE_BYTES 25'h1000000
`define EDS_EXT_NARROW_BYTES 25'h0010000
`define EDS_WINDOW_BASE 25'h0008000

`endif

// *** hw/eds_pkg.sv ***
// Types shared by the extended data address generator
package eds_pkg;
    typedef logic [23:0] eds_addr_t;
    typedef logic [9:0] rd_page_t;
    typedef logic [8:0] wr_page_t;
    typedef logic [15:0] data_ptr_t;
    typedef logic [2:0] evt_t;
endpackage

// *** hw/eds_addr_map.sv ***
// Combinational pointer-to-address translation for extended data space
`timescale 1ns/1ns
`default_nettype none
`include "eds_regs.svh"

module eds_addr_map
    import eds_pkg::*;
#(
    parameter bit WIDE_PORT = 1'b1
) (
    // Access
    input wire data_ptr_t ptr,
    input wire logic is_write,
    // Page selects
    input wire rd_page_t rd_page,
    input wire wr_page_t wr_page,
    // Result
    output eds_addr_t addr,
    output logic ext,
    output logic program_space_view,
    output logic page_zero,
    output logic reach_err
);
    localparam logic [24:0] REACH = WIDE_PORT ? `EDS_EXT_WIDE_BYTES : `EDS_EXT_NARROW_BYTES;

    wire window = ptr[`EDS_WINDOW_BIT];
    // Writes never see the read page, so the PROGRAM_SPACE_VIEW bit cannot steer them
    wire [8:0] page = is_write ? wr_page : rd_page[8:0];
    wire psv_sel = !is_write && rd_page[`EDS_PSV_BIT];
    wire [24:0] ext_addr = {1'b0, page, ptr[14:0]};

    assign ext = window;
    assign program_space_view = window && psv_sel;
    // Pointer offset is never carried into the page bits
    assign addr = window ? {page, ptr[14:0]} : {8'h00, ptr};
    assign page_zero = window && !psv_sel && (page == 9'h000);
    assign reach_err = window && !psv_sel && (page != 9'h000)
        && (ext_addr >= `EDS_WINDOW_BASE + REACH);
endmodule
`default_nettype wire

// *** hw/eds_read_timer.sv ***
// Access latency sequencer: write, base, extended and repeated extended reads
`timescale 1ns/1ns
`default_nettype none
`include "eds_regs.svh"

module eds_read_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Access taken this cycle
    input wire logic take,
    input wire logic ext_read,
    input wire logic repeat_run,
    // Progress
    output logic done_q,
    output logic idle_q,
    output logic [1:0] run_q
);
    logic [1:0] cnt_q;
    wire rep_slow = run_q < `EDS_REP_SLOW_COUNT;
    wire [1:0] lat = !ext_read ? `EDS_WRITE_CYCLES
        : !repeat_run ? `EDS_EXT_READ_CYCLES
        : rep_slow ? `EDS_REP_FIRST_CYCLES : `EDS_REP_LATER_CYCLES;
    wire [1:0] run_d = (ext_read && repeat_run) ? (rep_slow ? run_q + 2'h1 : run_q) : 2'h0;
    wire fin = (cnt_q == 2'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            done_q <= 1'b0;
            idle_q <= 1'b1;
            run_q <= 2'h0;
        end else if (take) begin
            cnt_q <= lat - 2'h1;
            done_q <= (lat == 2'h1);
            idle_q <= (lat == 2'h1);
            run_q <= run_d;
        end else begin
            cnt_q <= (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
            done_q <= fin;
            idle_q <= idle_q || fin;
        end
    end
endmodule
`default_nettype wire

// *** hw/extended_data_address_gen.sv ***
// Extended data space address generator with APB page registers and trap events
// What this block does
// R1: The extended space is split into 32-Kbyte pages, reads take the read page select, writes the write page select.
// R2: Program space view reads use only the read page select, the write page select never affects them.
// R3: A windowed read with read page bit 9 clear forms a 24-bit address from page bits 8:0 over pointer bits 14:0.
// R4: Software loads the page, places the offset and sets pointer bit 15 before an extended access.
// R5: An access through the window that selects page 0 raises an address error trap.
// R6: Each extended read outside a repeated run costs one extra cycle, so it takes two cycles.
// R7: In a repeated run of extended reads the first two take three cycles each and later ones one cycle.
// R8: The external reach is 16 Mbytes with the wide master port and 64K with the narrow one, above the 32K base data space.
// R9: A windowed write forms a 24-bit address from write page bits 8:0 over pointer bits 14:0.
// R10: Pointers below 8000h ignore both page selects and address the base data space directly.
// R11: Page selects never advance on pointer rollover, software updates them when crossing a page.
// R12: Every extended write completes in one cycle with no overhead.
// R13: A windowed read with read page bit 9 set is handed to the program space read path.
`timescale 1ns/1ns
`default_nettype none
`include "eds_regs.svh"

module extended_data_address_gen
    import eds_pkg::*;
#(
    parameter bit WIDE_PORT = 1'b1,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data access request
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_repeat,
    input wire data_ptr_t acc_ptr,
    output logic acc_ready,
    // Translated access
    output eds_addr_t acc_addr,
    output logic acc_ext,
    output logic acc_psv,
    output logic acc_pmp,
    output logic acc_trap,
    output logic acc_done,
    // Interrupt
    output logic irq
);
    rd_page_t rd_page_q;
    wr_page_t wr_page_q;
    evt_t status_q, mask_q;
    eds_addr_t addr_q;
    logic ext_q, psv_q, pmp_q, trap_q, irq_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic done_w, idle_w;
    logic [1:0] run_w;

    // Request handshake
    wire take = acc_valid && idle_w;
    wire ext_read = take && !acc_write && acc_ptr[`EDS_WINDOW_BIT];

    eds_addr_t map_addr;
    logic map_ext, map_psv, map_zero, map_reach;

    eds_addr_map #(
        .WIDE_PORT(WIDE_PORT)
    ) u_map (
        .ptr(acc_ptr),
        .is_write(acc_write),
        .rd_page(rd_page_q),
        .wr_page(wr_page_q),
        .addr(map_addr),
        .ext(map_ext),
        .program_space_view(map_psv),
        .page_zero(map_zero),
        .reach_err(map_reach)
    );

    eds_read_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .take(take),
        .ext_read(ext_read),
        .repeat_run(acc_repeat),
        .done_q(done_w),
        .idle_q(idle_w),
        .run_q(run_w)
    );

    // APB decode: answer one cycle into the access phase
    wire apb_acc = psel && penable && !pready_q;
    wire apb_fin = psel && penable && pready_q;
    wire hit_rd = paddr == ADDR_W'(`EDS_OFF_RD_PAGE);
    wire hit_wr = paddr == ADDR_W'(`EDS_OFF_WR_PAGE);
    wire hit_st = paddr == ADDR_W'(`EDS_OFF_STATUS);
    wire hit_mk = paddr == ADDR_W'(`EDS_OFF_MASK);
    wire hit_la = paddr == ADDR_W'(`EDS_OFF_LAST_ADDR);
    wire hit_rn = paddr == ADDR_W'(`EDS_OFF_RUN);
    wire mapped = hit_rd || hit_wr || hit_st || hit_mk || hit_la || hit_rn;
    wire wr_en = apb_fin && pwrite && mapped;

    logic [31:0] lane_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate
    wire [31:0] wdata = pwdata & lane_mask;

    wire [31:0] rd_mux =
        hit_rd ? {22'h0, rd_page_q} :
        hit_wr ? {23'h0, wr_page_q} :
        hit_st ? {29'h0, status_q} :
        hit_mk ? {29'h0, mask_q} :
        hit_la ? {7'h0, ext_q, addr_q} :
        hit_rn ? {30'h0, run_w} : 32'h0;

    // Events raised by a taken access
    evt_t evt;
    assign evt[`EDS_EVT_TRAP] = take && map_zero; // [R5]
    assign evt[`EDS_EVT_PSV] = take && map_psv; // [R13]
    assign evt[`EDS_EVT_REACH] = take && map_reach; // [R8]
    wire evt_t st_clr = (wr_en && hit_st) ? wdata[2:0] : 3'h0;
    // A new event wins over a simultaneous clear
    wire evt_t status_d = (status_q & ~st_clr) | evt;

    wire rd_wmask = wr_en && hit_rd;
    wire wr_wmask = wr_en && hit_wr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !mapped;
            prdata_q <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Page selects change only by software writes, never by pointer rollover
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_page_q <= `EDS_RD_PAGE_RESET;
            wr_page_q <= `EDS_WR_PAGE_RESET;
            mask_q <= `EDS_EVT_RESET;
        end else begin
            if (rd_wmask) begin
                rd_page_q <= wdata[9:0]; // [R1] [R11] [R4]
            end
            if (wr_wmask) begin
                wr_page_q <= wdata[8:0]; // [R1] [R11]
            end
            if (wr_en && hit_mk) begin
                mask_q <= wdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `EDS_EVT_RESET;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    // Translated address and kind, held until the next taken access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 24'h0;
            ext_q <= 1'b0;
            psv_q <= 1'b0;
            pmp_q <= 1'b0;
        end else if (take) begin
            addr_q <= map_addr; // [R3] [R9] [R10] [R2]
            ext_q <= map_ext;
            psv_q <= map_psv; // [R13]
            pmp_q <= map_ext && !map_psv && !map_zero && !map_reach; // [R8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= take && (map_zero || map_reach); // [R5]
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign acc_ready = idle_w;
    assign acc_addr = addr_q;
    assign acc_ext = ext_q;
    assign acc_psv = psv_q;
    assign acc_pmp = pmp_q;
    assign acc_trap = trap_q;
    assign acc_done = done_w; // [R6] [R7] [R12]
    assign irq = irq_q;

    // Helper views for the checks below
    wire [8:0] rd_low = rd_page_q[8:0];
    wire [14:0] ptr_low = acc_ptr[14:0];
    wire take_wr = take && acc_write;
    wire take_ext_wr = take_wr && acc_ptr[`EDS_WINDOW_BIT];
    wire take_plain_ext = ext_read && !acc_repeat;
    wire take_rep_slow = ext_read && acc_repeat && run_w < 2'h2;
    wire take_rep_fast = ext_read && acc_repeat && run_w >= 2'h2;
    wire take_dat_rd = ext_read && !rd_page_q[`EDS_PSV_BIT];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait1;
        !acc_done ##1 acc_done;
    endsequence
    sequence s_wait2;
        !acc_done [*2] ##1 acc_done;
    endsequence

    chk_write_single: assert property (take_ext_wr |=> acc_done) // [R12]
        else $error("extended write did not finish in one cycle");
    chk_ext_read_two: assert property (take_plain_ext |=> s_wait1 ##0 acc_ready) // [R6]
        else $error("extended read did not finish in two cycles");
    chk_rep_first_three: assert property (take_rep_slow |=> s_wait2) // [R7]
        else $error("early repeated read did not take three cycles");
    chk_rep_later_one: assert property (take_rep_fast |=> acc_done) // [R7]
        else $error("later repeated read did not take one cycle");
    chk_read_addr_form: assert property (take_dat_rd |=>
        acc_addr == {$past(rd_low), $past(ptr_low)} && acc_ext && !acc_psv) // [R3]
        else $error("read address not formed from read page and offset");
    chk_write_addr_form: assert property (take_ext_wr |=>
        acc_addr[14:0] == $past(ptr_low) && !acc_psv) // [R9]
        else $error("write address offset or view flag wrong");
    chk_base_direct: assert property (take && !acc_ptr[`EDS_WINDOW_BIT] |=>
        acc_addr[23:16] == 8'h00 && !acc_ext && !acc_trap && !acc_pmp) // [R10]
        else $error("base access used a page select");
    chk_page_zero_trap: assert property (take && map_zero |=>
        acc_trap && status_q[`EDS_EVT_TRAP] && !acc_pmp) // [R5]
        else $error("page 0 through the window did not trap");
    chk_psv_handoff: assert property (ext_read && rd_page_q[`EDS_PSV_BIT] |=>
        acc_psv && !acc_pmp && !acc_trap) // [R13]
        else $error("view read not handed to program space path");
    chk_page_hold: assert property (!wr_en |=> $stable(rd_page_q) && $stable(wr_page_q)) // [R11]
        else $error("page select changed without a software write");
    chk_irq_level: assert property (##1 irq == |($past(status_d) & $past(mask_q))) // [R5]
        else $error("interrupt does not follow masked status");

    // Further views for the latency, routing and register checks
    wire [8:0] wr_low = wr_page_q;
    wire [9:0] rd_wval = wdata[9:0];
    wire [8:0] wr_wval = wdata[8:0];
    wire take_psv = take && map_psv;
    wire take_base = take && !acc_ptr[`EDS_WINDOW_BIT];
    wire take_plain = take && !(ext_read && acc_repeat);
    wire take_pmp_rd = take_dat_rd && !map_zero && !map_reach;
    wire trap_and_clear = take && map_zero && wr_en && hit_st;

    // Request line stays low while a slow access is in flight
    sequence s_hold1;
        !acc_ready ##1 acc_ready;
    endsequence
    sequence s_hold2;
        !acc_ready [*2] ##1 acc_ready;
    endsequence

    // Access latency and the request line
    chk_ext_read_busy: assert property (take_plain_ext |=> s_hold1) // [R6]
        else $error("request line not low for the extended read overhead");
    chk_rep_first_busy: assert property (take_rep_slow |=> s_hold2) // [R7]
        else $error("request line not low for an early repeated read");
    chk_rep_later_ready: assert property (take_rep_fast |=> acc_ready) // [R7]
        else $error("later repeated read held the request line");
    chk_write_ready_kept: assert property (take_wr |=> acc_ready) // [R12]
        else $error("write held the request line");
    chk_done_ready: assert property (acc_done |-> acc_ready) // [R6]
        else $error("access finished while the request line stays low");

    // Repeat run counter
    chk_run_clear: assert property (take_plain |=> run_w == 2'h0) // [R7]
        else $error("repeat run count not cleared by a plain access");
    chk_run_limit: assert property (run_w != 2'h3) // [R7]
        else $error("repeat run count beyond its limit");

    // Program space view reads
    chk_psv_read_page: assert property (take_psv |=> // [R2]
        acc_addr == {$past(rd_low), $past(ptr_low)})
        else $error("view read did not use the read page");
    chk_psv_status: assert property (take_psv |=> status_q[`EDS_EVT_PSV]) // [R13]
        else $error("view read did not set its status bit");
    chk_psv_no_trap: assert property (take_psv |=> !acc_trap && !acc_pmp) // [R13]
        else $error("view read trapped or went to the master port");

    // Address forming and routing
    chk_write_page_form: assert property (take_ext_wr |=> // [R9]
        acc_addr[23:15] == $past(wr_low) && acc_ext)
        else $error("write address page bits not from the write page");
    chk_base_addr_full: assert property (take_base |=> // [R10]
        acc_addr == {8'h00, $past(acc_ptr)})
        else $error("base access address not the pointer itself");
    chk_reach_trap: assert property (take && map_reach |=> // [R8]
        acc_trap && status_q[`EDS_EVT_REACH])
        else $error("access beyond reach did not trap");
    chk_pmp_route: assert property (take_pmp_rd |=> acc_pmp) // [R8]
        else $error("extended data read not sent to the master port");

    // Traps and page select loads
    chk_trap_needs_take: assert property (acc_trap |-> $past(take)) // [R5]
        else $error("trap raised without a taken access");
    chk_trap_set_wins: assert property (trap_and_clear |=> status_q[`EDS_EVT_TRAP]) // [R5]
        else $error("clear in the trap cycle dropped the trap bit");
    chk_rd_page_load: assert property (wr_en && hit_rd |=> rd_page_q == $past(rd_wval)) // [R1]
        else $error("read page select did not load the written value");
    chk_wr_page_load: assert property (wr_en && hit_wr |=> wr_page_q == $past(wr_wval)) // [R1]
        else $error("write page select did not load the written value");
endmodule
`default_nettype wire

// *** sim/cpu_access_model.sv ***
// Behavioural CPU-side model issuing data accesses to the address generator
`timescale 1ns/1ns
`default_nettype none
module cpu_access_model
    import eds_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Request
    output var logic acc_valid,
    output var logic acc_write,
    output var logic acc_repeat,
    output var data_ptr_t acc_ptr,
    // Answer
    input wire logic acc_ready,
    input wire eds_addr_t acc_addr,
    input wire logic acc_ext,
    input wire logic acc_psv,
    input wire logic acc_pmp,
    input wire logic acc_trap,
    input wire logic acc_done
);
    int lat[8];
    int seen;
    eds_addr_t addr_seen;
    logic [3:0] flags_seen;
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_repeat = 1'b0;
        acc_ptr = 16'h0000;
    end
    // Issues n accesses back to back; flags_seen holds {trap, pmp, psv, ext}
    task automatic run(input data_ptr_t p, input logic wr, input logic rep, input int n);
        int k;
        int c;
        int g;
        k = 0;
        c = -99;
        g = 0;
        seen = 0;
        flags_seen = 4'h0;
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_repeat <= rep;
        acc_ptr <= p;
        while (seen < n && g < 60) begin
            @(posedge pclk);
            g++;
            c++;
            if (c == 1) begin
                addr_seen = acc_addr;
                flags_seen = flags_seen | {acc_trap, acc_pmp, acc_psv, acc_ext};
            end
            if (acc_done === 1'b1) begin
                lat[seen] = c;
                seen++;
            end
            if (acc_valid && acc_ready === 1'b1) begin
                c = 0;
                k++;
                if (k == n) acc_valid <= 1'b0;
                // Window pointer wraps from FFFE to 8000 and the page stays put
                acc_ptr <= {acc_ptr[15], acc_ptr[14:0] + 15'h0002};
            end
        end
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the extended data address generator
`timescale 1ns/1ns
`default_nettype none
`include "eds_regs.svh"
module tb
    import eds_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, f;
    logic acc_valid, acc_write, acc_repeat, acc_ready, acc_ext, acc_psv, acc_pmp;
    logic acc_trap, acc_done;
    data_ptr_t acc_ptr;
    eds_addr_t acc_addr, a;
    int l[8];
    int fails = 0;
    int checks_done = 0;
    extended_data_address_gen #(.WIDE_PORT(1'b1), .ADDR_W(8)) extended_data_address_gen_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .acc_valid, .acc_write, .acc_repeat, .acc_ptr, .acc_ready,
        .acc_addr, .acc_ext, .acc_psv, .acc_pmp, .acc_trap, .acc_done, .irq);
    cpu_access_model cpu_access_model_i (
        .pclk, .acc_valid, .acc_write, .acc_repeat, .acc_ptr, .acc_ready, .acc_addr,
        .acc_ext, .acc_psv, .acc_pmp, .acc_trap, .acc_done);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int g;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (g >= 20) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic go(input data_ptr_t p, input logic w, input logic r, input int n);
        cpu_access_model_i.run(p, w, r, n);
        check("acc_count", cpu_access_model_i.seen, n);
        a = cpu_access_model_i.addr_seen;
        f = cpu_access_model_i.flags_seen;
        l = cpu_access_model_i.lat;
    endtask
    task automatic t_regs();
        apb(1'b0, `EDS_OFF_RD_PAGE, 32'h0);
        check("rd_page", rd, 32'h00000001);
        apb(1'b0, `EDS_OFF_WR_PAGE, 32'h0);
        check("wr_page", rd, 32'h00000001);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h00000001);
        $display("Done: register reset values");
    endtask
    task automatic t_read_write();
        apb(1'b1, `EDS_OFF_RD_PAGE, 32'h00000002);
        apb(1'b1, `EDS_OFF_WR_PAGE, 32'h00000003);
        go(16'h8800, 1'b0, 1'b0, 1);
        check("rd_addr", a, 32'h00010800);
        check("rd_lat", l[0], 32'h2);
        check("rd_flags", f, 4'h5);
        apb(1'b0, `EDS_OFF_LAST_ADDR, 32'h0);
        check("last_addr", rd, 32'h01010800);
        go(16'hFFFE, 1'b1, 1'b0, 2);
        check("wr_addr", a, 32'h00018000);
        check("wr_lat", {l[0][15:0], l[1][15:0]}, 32'h00010001);
        apb(1'b0, `EDS_OFF_WR_PAGE, 32'h0);
        check("wr_page_kept", rd, 32'h00000003);
        $display("Done: extended read and write");
    endtask
    task automatic t_trap();
        apb(1'b1, `EDS_OFF_MASK, 32'h00000001);
        apb(1'b1, `EDS_OFF_RD_PAGE, 32'h00000000);
        go(16'h8000, 1'b0, 1'b0, 1);
        check("trap", f[3], 1'b1);
        apb(1'b0, `EDS_OFF_STATUS, 32'h0);
        check("trap_status", {rd[2:0], irq}, 4'h3);
        apb(1'b1, `EDS_OFF_STATUS, 32'h00000001);
        apb(1'b0, `EDS_OFF_STATUS, 32'h0);
        check("trap_clear", {rd[2:0], irq}, 4'h0);
        go(16'h1234, 1'b0, 1'b0, 1);
        check("base", {a, f, l[0][3:0]}, 32'h00123401);
        $display("Done: page zero trap and base space");
    endtask
    task automatic t_psv_reach();
        apb(1'b1, `EDS_OFF_RD_PAGE, 32'h00000200);
        apb(1'b1, `EDS_OFF_WR_PAGE, 32'h00000000);
        go(16'h8100, 1'b0, 1'b0, 1);
        check("psv_flags", f, 4'h3);
        apb(1'b0, `EDS_OFF_STATUS, 32'h0);
        check("psv_status", {rd[2:0], irq}, 4'h4);
        apb(1'b1, `EDS_OFF_STATUS, 32'h00000007);
        apb(1'b1, `EDS_OFF_RD_PAGE, 32'h000001FF);
        go(16'h8000, 1'b0, 1'b0, 1);
        check("reach", {a, f}, 32'h0FF80005);
        check("reach_addr", a, 32'h00FF8000);
        $display("Done: program space view and full reach");
    endtask
    task automatic t_repeat();
        apb(1'b1, `EDS_OFF_RD_PAGE, 32'h00000004);
        go(16'h8000, 1'b0, 1'b1, 4);
        check("rep_lat", {l[0][7:0], l[1][7:0], l[2][7:0], l[3][7:0]}, 32'h03030101);
        check("rep_addr", a, 32'h00020006);
        apb(1'b0, `EDS_OFF_RUN, 32'h0);
        check("run_count", rd, 32'h00000002);
        $display("Done: repeated extended reads");
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_read_write();
        t_trap();
        t_psv_reach();
        t_repeat();
        finish_test();
    end
endmodule
`default_nettype wire
